// ===== rtl/ddsm_cfg.svh
`ifndef DDSM_CFG_SVH
`define DDSM_CFG_SVH

// register addresses
`define DDSM_ADDR_CHAN_SEL 5'h00
`define DDSM_ADDR_FUNC_ONE 5'h01
`define DDSM_ADDR_CHAN_FUNC 5'h03
`define DDSM_ADDR_FREQ_BASE 5'h04
`define DDSM_ADDR_PHASE_BASE 5'h05
`define DDSM_ADDR_AMP_BASE 5'h06
`define DDSM_ADDR_PROF_FIRST 5'h0A
`define DDSM_ADDR_PROF_LAST 5'h18
// field positions
`define DDSM_CF_TYPE_HI 23
`define DDSM_CF_TYPE_LO 22
`define DDSM_CF_DAC_HI 9
`define DDSM_CF_DAC_LO 8
`define DDSM_CF_DAC_PD 7
`define DDSM_CF_DIG_PD 6
`define DDSM_F1_MUL_HI 22
`define DDSM_F1_MUL_LO 18
`define DDSM_F1_MAP_HI 14
`define DDSM_F1_MAP_LO 12
`define DDSM_F1_RAMP_HI 11
`define DDSM_F1_RAMP_LO 10
`define DDSM_F1_LVL_HI 9
`define DDSM_F1_LVL_LO 8
`define DDSM_F1_CLK_PD 7
`define DDSM_F1_PD_MODE 6
// reset values and limits
`define DDSM_CHAN_SEL_RST 2'h3
`define DDSM_FUNC_ONE_RST 24'h000000
`define DDSM_CHAN_FUNC_RST 24'h000300
`define DDSM_MUL_MIN 5'h04
`define DDSM_MUL_MAX 5'h14
`define DDSM_MAP_SPLIT 3'h5
`endif

// ===== rtl/ddsm_pkg.sv
package ddsm_pkg;
    // modulation type, encoded in declaration order
    typedef enum logic [1:0] {MOD_OFF, MOD_AMP, MOD_FREQ, MOD_PHASE} ddsm_mod_t;
    // modulation level count
    typedef enum logic [1:0] {LVL_2, LVL_4, LVL_8, LVL_16} ddsm_lvl_t;
    // ramp trigger source
    typedef enum logic [1:0] {RAMP_OFF, RAMP_P23, RAMP_P3, RAMP_SDIO} ddsm_ramp_t;
    // complete register state of the block
    typedef struct packed {
        logic [1:0] chan_en;
        logic [23:0] fr1;
        logic [1:0][23:0] channel_function_reg;
        logic [1:0][31:0] ftw;
        logic [1:0][15:0] pow;
        logic [1:0][23:0] acr;
        logic [1:0][14:0][31:0] prof;
        logic [3:0] pin_meta;
        logic [3:0] pin_sync;
        logic [2:0] sdio_meta;
        logic [2:0] sdio_sync;
        logic [1:0][31:0] freq;
        logic [1:0][13:0] phase;
        logic [1:0][9:0] amp;
        logic [1:0] ramp_up;
        logic [1:0] ramp_dn;
        logic [1:0] ch_dac_pd;
        logic [1:0] ch_dig_pd;
        logic [1:0] ch_clk_pd;
        logic dac_bias_pd;
        logic pll_pd;
        logic osc_pd;
        logic clkin_pd;
        logic [31:0] rdata;
    } ddsm_state_t;
endpackage

// ===== rtl/ddsm_ctrl.sv
`include "ddsm_cfg.svh"
module ddsm_ctrl
    import ddsm_pkg::*;
(
    input wire logic core_clk_in, // system clock
    input wire logic rst_in, // async reset, active high
    input wire logic ce_in, // clock enable, freezes state when low
    input wire logic wr_en_in, // register write strobe
    input wire logic rd_en_in, // register read strobe
    input wire logic [4:0] addr_in, // register address
    input wire logic [31:0] wdata_in, // register write data
    output logic [31:0] rdata_out, // register read data
    input wire logic [3:0] profile_pin_in, // profile pins, bit n is pin n
    input wire logic [2:0] sdio_ramp_in, // serial lines 1 to 3
    input wire logic ext_powerdown_pin_in, // external power-down pin
    output logic [1:0][31:0] freq_word_out, // per-channel frequency word
    output logic [1:0][13:0] phase_word_out, // per-channel phase word
    output logic [1:0][9:0] amp_word_out, // per-channel amplitude word
    output logic [1:0][1:0] dac_atten_out, // right shifts of full scale
    output logic [1:0] amp_ramp_up_out, // ramp-up request
    output logic [1:0] amp_ramp_down_out, // ramp-down request
    output logic [1:0] ch_dac_pd_out, // channel dac powered down
    output logic [1:0] ch_dig_pd_out, // channel digital powered down
    output logic [1:0] ch_clk_pd_out, // channel clock powered down
    output logic dac_bias_pd_out, // dac bias powered down
    output logic pll_pd_out, // pll powered down
    output logic osc_pd_out, // oscillator powered down
    output logic clkin_pd_out, // clock input powered down
    output logic sdio_single_bit_out // serial port forced to one-bit mode
);

    ddsm_state_t q; // registered state
    ddsm_state_t d; // next state
    logic [1:0][3:0] prof_idx; // selected profile index per channel
    logic [1:0] ramp_act; // ramp trigger active per channel
    logic [1:0] ramp_down; // ramp direction per channel
    ddsm_lvl_t lvl; // current level
    ddsm_ramp_t rsrc; // current ramp source
    logic [2:0] pmap; // current pin map
    logic mul_bypass; // multiplier out of range

    assign lvl = ddsm_lvl_t'(q.fr1[`DDSM_F1_LVL_HI:`DDSM_F1_LVL_LO]);
    assign rsrc = ddsm_ramp_t'(q.fr1[`DDSM_F1_RAMP_HI:`DDSM_F1_RAMP_LO]);
    assign pmap = q.fr1[`DDSM_F1_MAP_HI:`DDSM_F1_MAP_LO];
    assign mul_bypass = (q.fr1[`DDSM_F1_MUL_HI:`DDSM_F1_MUL_LO] < `DDSM_MUL_MIN) ||
                        (q.fr1[`DDSM_F1_MUL_HI:`DDSM_F1_MUL_LO] > `DDSM_MUL_MAX);

    // profile index of one channel from the synchronised pins
    function automatic logic [3:0] chan_idx(input logic ch, input ddsm_lvl_t lv,
                                            input ddsm_ramp_t rs, input logic [2:0] pm,
                                            input logic [3:0] p);
        logic [3:0] idx;
        idx = 4'h0;
        unique case (lv)
            LVL_2:
            begin
                if (rs == RAMP_P23)
                begin
                    // p2, p3 trigger ramps, p0/p1 modulate
                    if (pm == `DDSM_MAP_SPLIT)
                        idx = {3'h0, ch ? p[1] : p[0]};
                end
                else
                    idx = {3'h0, ch ? p[3] : p[2]};
            end
            LVL_4:
            begin
                if (pm == `DDSM_MAP_SPLIT)
                    idx = ch ? {2'h0, p[2], p[3]} : {2'h0, p[0], p[1]};
            end
            LVL_8:
            begin
                if (pm[1] && (pm[0] == ch))
                    idx = {1'b0, p[0], p[1], p[2]};
            end
            LVL_16:
            begin
                if (pm[1] && (pm[0] == ch))
                    idx = {p[0], p[1], p[2], p[3]};
            end
        endcase
        return idx;
    endfunction

    // ramp trigger of one channel, {active, down}
    function automatic logic [1:0] chan_ramp(input logic ch, input ddsm_ramp_t rs,
                                             input logic [2:0] pm, input logic [3:0] p,
                                             input logic [2:0] s);
        logic [1:0] r;
        r = 2'h0;
        unique case (rs)
            RAMP_OFF: r = 2'h0;
            RAMP_P23: r = {1'b1, ch ? p[3] : p[2]};
            RAMP_P3:
            begin
                if (pm[1] && (pm[0] == ch))
                    r = {1'b1, p[3]};
            end
            RAMP_SDIO:
            begin
                // line 1 enables, line 2 picks channel, line 3 down
                if (s[0] && (s[1] == ch))
                    r = {1'b1, s[2]};
            end
        endcase
        return r;
    endfunction

    // per-channel pin decode
    genvar gc;
    generate
        for (gc = 0; gc < 2; gc++)
        begin : g_chan
            logic [1:0] rr; // ramp result
            assign prof_idx[gc] = chan_idx(1'(gc), lvl, rsrc, pmap, q.pin_sync);
            assign rr = chan_ramp(1'(gc), rsrc, pmap, q.pin_sync, q.sdio_sync);
            // amplitude modulation owns the scaler, so no ramp then
            assign ramp_act[gc] = rr[1] &&
                (ddsm_mod_t'(q.channel_function_reg[gc][`DDSM_CF_TYPE_HI:`DDSM_CF_TYPE_LO]) != MOD_AMP);
            assign ramp_down[gc] = rr[0];
            // 11 full, 01 half, 10 quarter, 00 eighth
            always_comb
            begin
                unique case (q.channel_function_reg[gc][`DDSM_CF_DAC_HI:`DDSM_CF_DAC_LO])
                    2'h3: dac_atten_out[gc] = 2'h0;
                    2'h1: dac_atten_out[gc] = 2'h1;
                    2'h2: dac_atten_out[gc] = 2'h2;
                    2'h0: dac_atten_out[gc] = 2'h3;
                endcase
            end
        end
    endgenerate

    // next-state logic: registers, sync, word select, power-down
    always_comb
    begin
        logic [31:0] sel; // selected profile word
        logic [31:0] base; // aligned word zero
        ddsm_mod_t mt; // channel modulation type
        logic rch; // read channel
        sel = 32'h0;
        base = 32'h0;
        mt = MOD_OFF;
        rch = 1'b0;
        d = q;
        // two-stage pin synchronisers
        d.pin_meta = profile_pin_in;
        d.pin_sync = q.pin_meta;
        d.sdio_meta = sdio_ramp_in;
        d.sdio_sync = q.sdio_meta;
        // register writes, channel registers go to enabled channels
        if (wr_en_in)
        begin
            if (addr_in == `DDSM_ADDR_CHAN_SEL)
                d.chan_en = wdata_in[1:0];
            else if (addr_in == `DDSM_ADDR_FUNC_ONE)
                d.fr1 = wdata_in[23:0];
            for (int c = 0; c < 2; c++)
            begin
                if (q.chan_en[c])
                begin
                    if (addr_in == `DDSM_ADDR_CHAN_FUNC)
                        d.channel_function_reg[c] = wdata_in[23:0];
                    else if (addr_in == `DDSM_ADDR_FREQ_BASE)
                        d.ftw[c] = wdata_in;
                    else if (addr_in == `DDSM_ADDR_PHASE_BASE)
                        d.pow[c] = wdata_in[15:0];
                    else if (addr_in == `DDSM_ADDR_AMP_BASE)
                        d.acr[c] = wdata_in[23:0];
                    else if ((addr_in >= `DDSM_ADDR_PROF_FIRST) &&
                             (addr_in <= `DDSM_ADDR_PROF_LAST))
                        d.prof[c][4'(addr_in - `DDSM_ADDR_PROF_FIRST)] = wdata_in;
                end
            end
        end
        // register reads from channel 0 when it is enabled, otherwise from channel 1
        rch = q.chan_en[0] ? 1'b0 : 1'b1;
        if (rd_en_in)
        begin
            if (addr_in == `DDSM_ADDR_CHAN_SEL)
                d.rdata = {30'h0, q.chan_en};
            else if (addr_in == `DDSM_ADDR_FUNC_ONE)
                d.rdata = {8'h0, q.fr1};
            else if (addr_in == `DDSM_ADDR_CHAN_FUNC)
                d.rdata = {8'h0, q.channel_function_reg[rch]};
            else if (addr_in == `DDSM_ADDR_FREQ_BASE)
                d.rdata = q.ftw[rch];
            else if (addr_in == `DDSM_ADDR_PHASE_BASE)
                d.rdata = {16'h0, q.pow[rch]};
            else if (addr_in == `DDSM_ADDR_AMP_BASE)
                d.rdata = {8'h0, q.acr[rch]};
            else if ((addr_in >= `DDSM_ADDR_PROF_FIRST) && (addr_in <= `DDSM_ADDR_PROF_LAST))
                d.rdata = q.prof[rch][4'(addr_in - `DDSM_ADDR_PROF_FIRST)];
            else
                d.rdata = 32'h0; // unmapped address reads zero
        end
        // word selection, held while channel logic is powered down
        for (int c = 0; c < 2; c++)
        begin
            mt = ddsm_mod_t'(q.channel_function_reg[c][`DDSM_CF_TYPE_HI:`DDSM_CF_TYPE_LO]);
            unique case (mt)
                MOD_FREQ: base = q.ftw[c];
                MOD_PHASE: base = {q.pow[c][13:0], 18'h0};
                MOD_AMP: base = {q.acr[c][9:0], 22'h0};
                MOD_OFF: base = 32'h0;
            endcase
            sel = (prof_idx[c] == 4'h0) ? base : q.prof[c][4'(prof_idx[c] - 4'h1)];
            if (!q.ch_dig_pd[c])
            begin
                d.freq[c] = (mt == MOD_FREQ) ? sel : q.ftw[c];
                d.phase[c] = (mt == MOD_PHASE) ? sel[31:18] : q.pow[c][13:0];
                d.amp[c] = (mt == MOD_AMP) ? sel[31:22] : q.acr[c][9:0];
                d.ramp_up[c] = ramp_act[c] && !ramp_down[c];
                d.ramp_dn[c] = ramp_act[c] && ramp_down[c];
            end
        end
        // power-down, one means low power
        if (ext_powerdown_pin_in)
        begin
            if (q.fr1[`DDSM_F1_PD_MODE])
            begin
                // full power-down
                d.ch_dac_pd = 2'h3;
                d.ch_dig_pd = 2'h3;
                d.ch_clk_pd = 2'h3;
                d.dac_bias_pd = 1'b1;
                d.pll_pd = 1'b1;
                d.osc_pd = 1'b1;
                d.clkin_pd = 1'b1;
            end
            else
            begin
                // fast recovery: digital logic down, pll down only when the multiplier is bypassed
                d.ch_dac_pd = 2'h0;
                d.ch_dig_pd = 2'h3;
                d.ch_clk_pd = 2'h0;
                d.dac_bias_pd = 1'b0;
                d.pll_pd = mul_bypass;
                d.osc_pd = 1'b0;
                d.clkin_pd = 1'b0;
            end
        end
        else
        begin
            // software bits rule while the pin is low
            for (int c = 0; c < 2; c++)
            begin
                d.ch_dac_pd[c] = q.channel_function_reg[c][`DDSM_CF_DAC_PD];
                d.ch_dig_pd[c] = q.channel_function_reg[c][`DDSM_CF_DIG_PD];
                d.ch_clk_pd[c] = q.channel_function_reg[c][`DDSM_CF_DIG_PD];
            end
            d.dac_bias_pd = 1'b0;
            d.pll_pd = mul_bypass;
            d.osc_pd = 1'b0;
            d.clkin_pd = q.fr1[`DDSM_F1_CLK_PD];
        end
    end

    // state register, frozen while clock enable is low
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            q <= '0;
            q.chan_en <= `DDSM_CHAN_SEL_RST;
            q.fr1 <= `DDSM_FUNC_ONE_RST;
            q.channel_function_reg <= {`DDSM_CHAN_FUNC_RST, `DDSM_CHAN_FUNC_RST};
            q.pll_pd <= 1'b1;
        end
        else if (ce_in)
            q <= d;
    end

    // outputs
    assign rdata_out = q.rdata;
    assign freq_word_out = q.freq;
    assign phase_word_out = q.phase;
    assign amp_word_out = q.amp;
    assign amp_ramp_up_out = q.ramp_up;
    assign amp_ramp_down_out = q.ramp_dn;
    assign ch_dac_pd_out = q.ch_dac_pd;
    assign ch_dig_pd_out = q.ch_dig_pd;
    assign ch_clk_pd_out = q.ch_clk_pd;
    assign dac_bias_pd_out = q.dac_bias_pd;
    assign pll_pd_out = q.pll_pd;
    assign osc_pd_out = q.osc_pd;
    assign clkin_pd_out = q.clkin_pd;
    assign sdio_single_bit_out = (rsrc == RAMP_SDIO);

    // checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    dac_scale_a: assert property ((q.channel_function_reg[0][9:8] == 2'h1) |-> (dac_atten_out[0] == 2'h1) ##0
        (q.channel_function_reg[0][9:8] != 2'h0 || dac_atten_out[0] == 2'h3))
        else $error("dac scale decode wrong");
    sw_pd_a: assert property (ce_in && !ext_powerdown_pin_in |=>
        (ch_dac_pd_out == {$past(q.channel_function_reg[1][7]), $past(q.channel_function_reg[0][7])}))
        else $error("software dac power-down not followed");
    pd_full_a: assert property (ce_in && ext_powerdown_pin_in && q.fr1[6] |=>
        pll_pd_out && dac_bias_pd_out && (ch_dac_pd_out == 2'h3) && clkin_pd_out)
        else $error("full power-down incomplete");
    pd_fast_a: assert property (ce_in && ext_powerdown_pin_in && !q.fr1[6] |=>
        !dac_bias_pd_out && !osc_pd_out && (ch_dig_pd_out == 2'h3))
        else $error("fast power-down wrong");
    sw_bits_ignored_a: assert property (ce_in && ext_powerdown_pin_in && !q.fr1[6] &&
        q.channel_function_reg[0][7] && q.fr1[7] |=> !ch_dac_pd_out[0] && !clkin_pd_out)
        else $error("software bits not ignored with pin high");
    pll_bypass_a: assert property (ce_in && mul_bypass && !ext_powerdown_pin_in |=>
        pll_pd_out)
        else $error("pll not shut down when bypassed");
    two_level_a: assert property (ce_in && lvl == LVL_2 && rsrc == RAMP_OFF &&
        q.channel_function_reg[0][23:22] == 2'h2 && !q.ch_dig_pd[0] && q.pin_sync[2] |=>
        freq_word_out[0] == $past(q.prof[0][0]))
        else $error("two-level high pin did not pick word one");
    ramp_pol_a: assert property (ce_in && rsrc == RAMP_P23 && q.channel_function_reg[0][23:22] != 2'h1 &&
        !q.ch_dig_pd[0] && !q.pin_sync[2] |=> amp_ramp_up_out[0] && !amp_ramp_down_out[0])
        else $error("low ramp pin did not ramp up");
    ramp_no_am_a: assert property (ce_in && q.channel_function_reg[1][23:22] == 2'h1 |=>
        !amp_ramp_up_out[1] && !amp_ramp_down_out[1])
        else $error("ramp active under amplitude modulation");
    sdio_mode_a: assert property ((q.fr1[11:10] == 2'h3) == sdio_single_bit_out)
        else $error("single-bit serial mode not forced");

    four_level_c: cover property (ce_in && lvl == LVL_4 && pmap == 3'h5);
    sixteen_level_c: cover property (ce_in && lvl == LVL_16 && prof_idx[1] == 4'hE);
    sdio_ramp_c: cover property (ce_in && rsrc == RAMP_SDIO && amp_ramp_down_out[1]);
    full_pd_c: cover property (pll_pd_out && dac_bias_pd_out);

endmodule // ddsm_ctrl

// ===== tb/ddsm_host_model.sv
// host side: drives the register strobes, profile pins, serial lines and power-down pin
module ddsm_host_model
(
    input wire logic core_clk_in, // system clock
    input wire logic [31:0] rdata_in, // read data from the block
    output logic wr_en_out, // write strobe
    output logic rd_en_out, // read strobe
    output logic [4:0] addr_out, // register address
    output logic [31:0] wdata_out, // write data
    output logic [3:0] profile_pin_out, // profile pins
    output logic [2:0] sdio_ramp_out, // serial lines 1 to 3
    output logic ext_powerdown_pin_out // external power-down pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle levels at time zero
    initial
    begin
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
        addr_out = 5'h1F;
        wdata_out = 32'h0;
        profile_pin_out = 4'h0;
        sdio_ramp_out = 3'h0;
        ext_powerdown_pin_out = 1'b0;
    end
    // one write, taken at the edge that sees the strobe
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] v;
        v = d;
        if (a == 5'h03)
        begin
            v[14] = 1'b0; // sweep stays off while pins modulate
        end
        @(posedge core_clk_in);
        wr_en_out <= 1'b1;
        addr_out <= a;
        wdata_out <= v;
        @(posedge core_clk_in);
        wr_en_out <= 1'b0;
        addr_out <= ~a; // released lines do not keep the old value
        wdata_out <= ~v;
    endtask
    // one read, data lands at the edge that sees the strobe
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge core_clk_in);
        rd_en_out <= 1'b1;
        addr_out <= a;
        @(posedge core_clk_in);
        rd_en_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask
    // level inputs: pins, serial lines, power-down pin
    task automatic drive(input logic [3:0] p, input logic [2:0] s, input logic pd);
        @(posedge core_clk_in);
        profile_pin_out <= p;
        sdio_ramp_out <= s;
        ext_powerdown_pin_out <= pd;
    endtask
endmodule // ddsm_host_model

// ===== tb/dds_modulation_powerdown_ctrl_tb_top.sv
// self-checking bench: register cases, table of settings, then ramp and reset cases
module dds_modulation_powerdown_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ddsm_pkg::*;
    // one table row: inputs, then expected outputs
    typedef struct packed {
        logic pd;
        logic [23:0] fr1;
        logic [23:0] channel_function_reg;
        logic [3:0] pins;
        logic [3:0] atten;
        logic [9:0] pdv;
        logic chkf;
        logic [31:0] f0;
        logic [31:0] f1;
    } ddsm_row_t;
    logic core_clk_in, rst_in, wr_en, rd_en, pd_pin, sbit;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, rv;
    logic [3:0] pins;
    logic [2:0] sdio;
    logic [1:0][31:0] fw;
    logic [1:0][13:0] pw;
    logic [1:0][9:0] aw;
    logic [1:0][1:0] att;
    logic [1:0] rup, rdn, cdac, cdig, cclk;
    logic bias, pll, osc, clkin;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    ddsm_row_t rows [14] = '{
        '{0, 24'h000000, 24'h000300, 4'h0, 4'h0, 10'h004, 1, 32'h00001000, 32'h00002000},
        '{0, 24'h000080, 24'h000180, 4'h0, 4'h5, 10'h305, 0, 32'h0, 32'h0},
        '{0, 24'h000000, 24'h000240, 4'h0, 4'hA, 10'h0F4, 0, 32'h0, 32'h0},
        '{0, 24'h000000, 24'h0000C0, 4'h0, 4'hF, 10'h3F4, 0, 32'h0, 32'h0},
        '{1, 24'h000080, 24'h0000C0, 4'h0, 4'hF, 10'h0C4, 0, 32'h0, 32'h0},
        '{1, 24'h000040, 24'h0000C0, 4'h0, 4'hF, 10'h3FF, 0, 32'h0, 32'h0},
        '{0, 24'h140000, 24'h000300, 4'h0, 4'h0, 10'h000, 1, 32'h00001000, 32'h00002000},
        '{0, 24'h540000, 24'h000300, 4'h0, 4'h0, 10'h004, 1, 32'h00001000, 32'h00002000},
        '{0, 24'h000000, 24'h800300, 4'h4, 4'h0, 10'h004, 1, 32'h10000001, 32'h00002000},
        '{0, 24'h000000, 24'h800300, 4'hB, 4'h0, 10'h004, 1, 32'h00001000, 32'h01000055},
        '{0, 24'h005100, 24'h800300, 4'hB, 4'h0, 10'h004, 1, 32'h30000003, 32'h01000055},
        '{0, 24'h002200, 24'h800300, 4'h7, 4'h0, 10'h004, 1, 32'h70000007, 32'h00002000},
        '{0, 24'h002300, 24'h800300, 4'hB, 4'h0, 10'h004, 1, 32'hD000000D, 32'h00002000},
        '{0, 24'h003300, 24'h800300, 4'h7, 4'h0, 10'h004, 1, 32'h00001000, 32'h0E000055}};
    // system clock, 20 ns period
    initial
    begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    ddsm_host_model i_host (.core_clk_in(core_clk_in), .rdata_in(rdata), .wr_en_out(wr_en),
        .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata), .profile_pin_out(pins),
        .sdio_ramp_out(sdio), .ext_powerdown_pin_out(pd_pin));
    ddsm_ctrl i_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(1'b1),
        .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata),
        .rdata_out(rdata), .profile_pin_in(pins), .sdio_ramp_in(sdio),
        .ext_powerdown_pin_in(pd_pin), .freq_word_out(fw), .phase_word_out(pw),
        .amp_word_out(aw), .dac_atten_out(att), .amp_ramp_up_out(rup),
        .amp_ramp_down_out(rdn), .ch_dac_pd_out(cdac), .ch_dig_pd_out(cdig),
        .ch_clk_pd_out(cclk), .dac_bias_pd_out(bias), .pll_pd_out(pll), .osc_pd_out(osc),
        .clkin_pd_out(clkin), .sdio_single_bit_out(sbit));
    // counts and reports one comparison
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // hang guard
    always @(posedge core_clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            n_fail++;
            finish_test();
        end
    end
    // main sequence
    initial
    begin
        rst_in = 1'b1;
        repeat (10) @(posedge core_clk_in);
        rst_in <= 1'b0;
        i_host.rd(5'h00, rv);
        chk("chan_en", 32'h3, rv);
        i_host.rd(5'h03, rv);
        chk("cfr", 32'h300, rv);
        chk("pll_pd", 32'h1, {31'h0, pll});
        i_host.wr(5'h02, 32'hFFFFFFFF);
        i_host.rd(5'h02, rv);
        chk("unmapped", 32'h0, rv);
        // per-channel base and profile words
        for (int c = 0; c < 2; c++)
        begin
            i_host.wr(5'h00, c == 0 ? 32'h1 : 32'h2);
            i_host.wr(5'h04, c == 0 ? 32'h1000 : 32'h2000);
            for (logic [4:0] k = 5'h1; k <= 5'hF; k++)
            begin
                i_host.wr(5'h09 + k, c == 0 ? {k[3:0], 24'h0, k[3:0]} : {4'h0, k[3:0], 24'h55});
            end
        end
        i_host.rd(5'h18, rv);
        chk("word15", 32'h0F000055, rv);
        // table of settings
        foreach (rows[i])
        begin
            i_host.wr(5'h00, 32'h3);
            i_host.wr(5'h01, {8'h0, rows[i].fr1});
            i_host.wr(5'h03, {8'h0, rows[i].channel_function_reg});
            i_host.drive(rows[i].pins, 3'h0, rows[i].pd);
            repeat (6) @(posedge core_clk_in);
            chk("atten", {28'h0, rows[i].atten}, {28'h0, att});
            chk("pd", {22'h0, rows[i].pdv}, {22'h0, cdac, cdig, cclk, bias, pll, osc, clkin});
            if (rows[i].chkf)
            begin
                chk("freq0", rows[i].f0, fw[0]);
                chk("freq1", rows[i].f1, fw[1]);
            end
        end
        // ramp from profile pins, two-level with map 101
        i_host.wr(5'h01, 32'h5400);
        i_host.drive(4'h9, 3'h0, 1'b0);
        repeat (5) @(posedge core_clk_in);
        chk("ramp_up", 32'h1, {30'h0, rup});
        chk("ramp_dn", 32'h2, {30'h0, rdn});
        chk("freq0 r", 32'h10000001, fw[0]);
        chk("freq1 r", 32'h2000, fw[1]);
        // ramp held off on an amplitude-modulated channel
        i_host.wr(5'h00, 32'h2);
        i_host.wr(5'h03, 32'h400300);
        repeat (5) @(posedge core_clk_in);
        chk("ramp_dn am", 32'h0, {30'h0, rdn});
        i_host.wr(5'h03, 32'h800300);
        // serial lines as ramp triggers
        i_host.wr(5'h01, 32'hC00);
        i_host.drive(4'h0, 3'h3, 1'b0);
        repeat (5) @(posedge core_clk_in);
        chk("single_bit", 32'h1, {31'h0, sbit});
        chk("ramp_up s", 32'h2, {30'h0, rup});
        i_host.drive(4'h0, 3'h7, 1'b0);
        repeat (5) @(posedge core_clk_in);
        chk("ramp_dn s", 32'h2, {30'h0, rdn});
        chk("freq0 s", 32'h1000, fw[0]);
        chk("freq1 s", 32'h2000, fw[1]);
        // phase on channel zero, amplitude on channel one, two-level
        i_host.wr(5'h00, 32'h1);
        i_host.wr(5'h03, 32'hC00300);
        i_host.wr(5'h00, 32'h2);
        i_host.wr(5'h03, 32'h400300);
        i_host.wr(5'h01, 32'h0);
        i_host.drive(4'hC, 3'h0, 1'b0);
        repeat (5) @(posedge core_clk_in);
        chk("phase0", 32'h400, {18'h0, pw[0]});
        chk("phase1", 32'h0, {18'h0, pw[1]});
        chk("amp0", 32'h0, {22'h0, aw[0]});
        chk("amp1", 32'h4, {22'h0, aw[1]});
        // reset in mid-run
        @(posedge core_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        chk("pll_pd rst", 32'h1, {31'h0, pll});
        chk("freq0 rst", 32'h0, fw[0]);
        chk("atten rst", 32'h0, {28'h0, att});
        rst_in <= 1'b0;
        i_host.rd(5'h01, rv);
        chk("fr1 rst", 32'h0, rv);
        finish_test();
    end
endmodule // dds_modulation_powerdown_ctrl_tb_top
